// ### verilog/dhi_host.sv
`timescale 1ns/100ps
`default_nettype none

module dhi_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// Drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
	logic [AW-1:0] wr_ptr_ff, rd_ptr_ff;
	logic [AW:0] cnt_ff, nxt_cnt;
	logic in_ready_ff, out_valid_ff, push, pop;

	// Depth must be a power of two so pointers wrap by themselves
	assign push = in_valid && in_ready_ff;
	assign pop = out_valid_ff && out_ready;
	assign in_ready = in_ready_ff;
	assign out_valid = out_valid_ff;
	assign out_data = mem_ff[rd_ptr_ff];

	always_comb begin
		nxt_cnt = cnt_ff;
		if (push && !pop) begin
			nxt_cnt = cnt_ff + 1'b1;
		end else if (pop && !push) begin
			nxt_cnt = cnt_ff - 1'b1;
		end
	end

	// Pointers and flags, flags registered from the next count
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wr_ptr_ff <= '0;
			rd_ptr_ff <= '0;
			cnt_ff <= '0;
			in_ready_ff <= 1'b0;
			out_valid_ff <= 1'b0;
		end else begin
			if (push) wr_ptr_ff <= wr_ptr_ff + 1'b1;
			if (pop) rd_ptr_ff <= rd_ptr_ff + 1'b1;
			cnt_ff <= nxt_cnt;
			in_ready_ff <= nxt_cnt != (AW+1)'(DEPTH);
			out_valid_ff <= nxt_cnt != '0;
		end
	end

	// Storage
	always_ff @(posedge clk) begin
		if (push) mem_ff[wr_ptr_ff] <= in_data;
	end
endmodule

module dhi_host (
	// System clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// Straps, taken while reset is held
	input wire dhi_pkg::dhi_mode_t port_mode,
	input wire logic osc_internal,
	// Requests
	input wire logic req_valid,
	output logic req_ready,
	input wire logic req_read,
	input wire logic req_dc,
	input wire logic [7:0] req_data,
	// Read answers
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	// Link to the device
	dhi_link_if.host_mp lnk
);
	import dhi_pkg::*;

	dhi_mode_t mode_ff;
	dhi_hstate_t state_ff;
	logic osc_int_ff, init_done_ff, lclk_ff, primed_ff, dummy_ff, ext_clk_ff;
	logic cur_read_ff, cur_dc_ff, rsp_valid_ff;
	logic [7:0] cur_data_ff, rsp_data_ff, init_cnt_ff, ph_cnt_ff, d_meta_ff, d_s_ff;
	logic [3:0] div_cnt_ff;
	logic [2:0] bit_idx_ff;
	logic f_valid, f_pop, ph_done, f_is_dread, active, is_ser;
	logic [FIFO_W-1:0] f_data;

	dhi_fifo #(
		.WIDTH(FIFO_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk_sys),
		.rst_n(rst_n),
		.in_valid(req_valid),
		.in_ready(req_ready),
		.in_data({req_read, req_dc, req_data}),
		.out_valid(f_valid),
		.out_ready(f_pop),
		.out_data(f_data)
	);

	assign is_ser = mode_ff == DHI_MSER;
	assign ph_done = ph_cnt_ff == PHASE_LAST;
	assign f_is_dread = f_data[9] && f_data[8];
	// In the parallel modes a first pixel read is run once as a dummy before the entry is taken
	assign f_pop = state_ff == H_IDLE && init_done_ff && f_valid &&
		!(f_is_dread && !primed_ff && !is_ser);
	assign active = state_ff != H_IDLE && state_ff != H_GAP;
	assign rsp_valid = rsp_valid_ff;
	assign rsp_data = rsp_data_ff;

	// Link clock divider and strap capture
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			div_cnt_ff <= 4'h0;
			lclk_ff <= 1'b0;
			mode_ff <= port_mode;
			osc_int_ff <= osc_internal;
		end else if (div_cnt_ff == LINK_HALF_LAST) begin
			div_cnt_ff <= 4'h0;
			lclk_ff <= !lclk_ff;
		end else begin
			div_cnt_ff <= div_cnt_ff + 4'h1;
		end
	end

	// External display clock at half the link rate; it moves on link falls,
	// so the device never samples it while it changes
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			ext_clk_ff <= 1'b0;
		end else if (div_cnt_ff == LINK_HALF_LAST && lclk_ff) begin
			ext_clk_ff <= !ext_clk_ff;
		end
	end

	// Device init pulse after our own reset
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			init_cnt_ff <= 8'h00;
			init_done_ff <= 1'b0;
		end else if (!init_done_ff) begin
			init_cnt_ff <= init_cnt_ff + 8'h01;
			init_done_ff <= init_cnt_ff == INIT_LAST;
		end
	end

	// Read-back bus comes from the device domain
	always_ff @(posedge clk_sys) begin
		d_meta_ff <= lnk.d_bus;
		d_s_ff <= d_meta_ff;
	end

	// Transfer sequencer
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			state_ff <= H_IDLE;
			ph_cnt_ff <= 8'h00;
			cur_read_ff <= 1'b0;
			cur_dc_ff <= 1'b0;
			cur_data_ff <= 8'h00;
			dummy_ff <= 1'b0;
			bit_idx_ff <= 3'h7;
			primed_ff <= 1'b0;
		end else begin
			ph_cnt_ff <= (state_ff == H_IDLE || ph_done) ? 8'h00 : ph_cnt_ff + 8'h01;
			case (state_ff)
				H_IDLE: if (init_done_ff && f_valid) begin
					cur_read_ff <= f_data[9];
					cur_dc_ff <= f_data[8];
					cur_data_ff <= f_data[7:0];
					dummy_ff <= f_is_dread && !primed_ff;
					bit_idx_ff <= 3'h7;
					if (is_ser) begin
						state_ff <= f_data[9] ? H_IDLE : H_SER_LO;
					end else begin
						state_ff <= H_SETUP;
					end
				end
				H_SETUP: if (ph_done) state_ff <= H_STROBE;
				H_STROBE: if (ph_done) state_ff <= H_HOLD;
				H_SER_LO: if (ph_done) state_ff <= H_SER_HI;
				H_SER_HI: if (ph_done) begin
					if (bit_idx_ff == 3'h0) begin
						state_ff <= H_HOLD;
					end else begin
						bit_idx_ff <= bit_idx_ff - 3'h1;
						state_ff <= H_SER_LO;
					end
				end
				H_HOLD: if (ph_done) state_ff <= H_GAP;
				H_GAP: if (ph_done) begin
					state_ff <= H_IDLE;
					if (cur_read_ff && cur_dc_ff) begin
						primed_ff <= 1'b1;
					end else if (!cur_read_ff) begin
						primed_ff <= 1'b0; // Writes move the device's read pointer
					end
				end
				default: state_ff <= H_IDLE;
			endcase
		end
	end

	// Read answers, the dummy byte is dropped
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			rsp_valid_ff <= 1'b0;
			rsp_data_ff <= 8'h00;
		end else begin
			rsp_valid_ff <= state_ff == H_STROBE && ph_done && cur_read_ff && !dummy_ff;
			if (state_ff == H_STROBE && ph_done) rsp_data_ff <= d_s_ff;
		end
	end

	// Link pins, all registered
	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			lnk.link_clk <= 1'b0;
			lnk.init_pin_n <= 1'b0;
			lnk.cs_n <= 1'b1;
			lnk.dc <= 1'b0;
			lnk.rw_wr_n <= 1'b1;
			lnk.e_rd_n <= 1'b0;
			lnk.d_host_o <= 8'h00;
			lnk.d_host_oe <= 1'b0;
			{lnk.host_port_pick_2, lnk.host_port_pick_1, lnk.host_port_pick_0} <= 3'h7;
			lnk.osc_source_pick <= 1'b1;
			lnk.ext_osc_input <= 1'b0;
			lnk.func_enable <= 1'b1;
		end else begin
			lnk.link_clk <= lclk_ff;
			lnk.init_pin_n <= init_done_ff;
			lnk.func_enable <= 1'b1;
			lnk.osc_source_pick <= osc_int_ff;
			lnk.ext_osc_input <= !osc_int_ff && ext_clk_ff;
			case (mode_ff)
				DHI_M6800: {lnk.host_port_pick_2, lnk.host_port_pick_1,
					lnk.host_port_pick_0} <= PICK_6800;
				DHI_M8080: {lnk.host_port_pick_2, lnk.host_port_pick_1,
					lnk.host_port_pick_0} <= PICK_8080;
				default: {lnk.host_port_pick_2, lnk.host_port_pick_1,
					lnk.host_port_pick_0} <= PICK_SER;
			endcase
			lnk.cs_n <= !active;
			lnk.dc <= cur_dc_ff;
			if (mode_ff == DHI_M8080) begin
				lnk.rw_wr_n <= !(state_ff == H_STROBE && !cur_read_ff);
				lnk.e_rd_n <= !(state_ff == H_STROBE && cur_read_ff);
			end else begin
				lnk.rw_wr_n <= cur_read_ff;
				lnk.e_rd_n <= state_ff == H_STROBE && !is_ser;
			end
			if (is_ser) begin
				lnk.d_host_o <= {6'h00, cur_data_ff[bit_idx_ff], state_ff == H_SER_HI};
				lnk.d_host_oe <= active;
			end else begin
				lnk.d_host_o <= cur_data_ff;
				lnk.d_host_oe <= active && !cur_read_ff;
			end
		end
	end
endmodule

`default_nettype wire

// ### verilog/dhi_pkg.sv
`default_nettype none

package dhi_pkg;
	// Clock and phase timing of the host end, and the device's display clock divider
	localparam int SYS_PERIOD_NS = 25;
	localparam logic [3:0] LINK_HALF_LAST = 4'h3;
	localparam int PHASE_NS = 1600;
	localparam int PHASE_CYC = (PHASE_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [7:0] PHASE_LAST = 8'(PHASE_CYC - 1);
	localparam int INIT_NS = 3200;
	localparam int INIT_CYC = (INIT_NS + SYS_PERIOD_NS - 1) / SYS_PERIOD_NS;
	localparam logic [7:0] INIT_LAST = 8'(INIT_CYC - 1);
	localparam logic [3:0] OSC_DIV_LAST = 4'h7;

	// Host port selection
	typedef enum logic [1:0] {
		DHI_M6800 = 2'b00,
		DHI_M8080 = 2'b01,
		DHI_MSER = 2'b10,
		DHI_MNONE = 2'b11
	} dhi_mode_t;
	localparam logic [2:0] PICK_6800 = 3'h4;
	localparam logic [2:0] PICK_8080 = 3'h6;
	localparam logic [2:0] PICK_SER = 3'h0;

	// Host sequencer states
	typedef enum logic [2:0] {
		H_IDLE = 3'b000,
		H_SETUP = 3'b001,
		H_STROBE = 3'b010,
		H_HOLD = 3'b011,
		H_GAP = 3'b100,
		H_SER_LO = 3'b101,
		H_SER_HI = 3'b110
	} dhi_hstate_t;

	// Pixel store geometry, one byte holds two pixels
	localparam int COL_W = 6;
	localparam int ROW_W = 7;
	localparam int ADDR_W = 13;
	localparam int MEM_BYTES = 5120;
	localparam logic [5:0] COL_END_RST = 6'h3F;
	localparam logic [6:0] ROW_END_RST = 7'h4F;
	localparam logic [5:0] COL_MAX = 6'h3F;

	// Commands and register fields
	localparam logic [7:0] CMD_COL_ADDR = 8'h15;
	localparam logic [7:0] CMD_ROW_ADDR = 8'h75;
	localparam logic [7:0] CMD_REMAP = 8'hA0;
	localparam logic [7:0] CMD_DISP_OFF = 8'hAE;
	localparam logic [7:0] CMD_DISP_ON = 8'hAF;
	localparam int REMAP_W = 7;
	localparam logic [6:0] REMAP_RST = 7'h00;
	localparam int REMAP_COL = 0;
	localparam int REMAP_NIB = 1;
	localparam int REMAP_VINC = 2;
	localparam int STAT_OFF_BIT = 6;

	// Widths
	localparam int PIN_W = 19;
	localparam int FIFO_W = 10;
	localparam int FIFO_DEPTH = 8;

	function automatic dhi_mode_t pick_to_mode(input logic [2:0] pick);
		case (pick)
			PICK_6800: return DHI_M6800;
			PICK_8080: return DHI_M8080;
			PICK_SER: return DHI_MSER;
			default: return DHI_MNONE;
		endcase
	endfunction
endpackage

`default_nettype wire

// ### verilog/dhi_link_if.sv
`timescale 1ns/100ps
`default_nettype none

interface dhi_link_if;
	logic link_clk;
	logic init_pin_n;
	logic cs_n;
	logic dc;
	logic rw_wr_n;
	logic e_rd_n;
	logic host_port_pick_0;
	logic host_port_pick_1;
	logic host_port_pick_2;
	logic osc_source_pick;
	logic ext_osc_input;
	logic func_enable;
	logic [7:0] d_host_o;
	logic d_host_oe;
	logic [7:0] d_dev_o;
	logic d_dev_oe;
	wire logic [7:0] d_bus;

	// Resolved bus level, pulled up when nobody drives
	assign d_bus = d_dev_oe ? d_dev_o : (d_host_oe ? d_host_o : 8'hFF);

	modport host_mp(
		output link_clk, init_pin_n, cs_n, dc, rw_wr_n, e_rd_n,
		output host_port_pick_0, host_port_pick_1, host_port_pick_2,
		output osc_source_pick, ext_osc_input, func_enable, d_host_o, d_host_oe,
		input d_bus
	);
	modport dev_mp(
		input link_clk, init_pin_n, cs_n, dc, rw_wr_n, e_rd_n,
		input host_port_pick_0, host_port_pick_1, host_port_pick_2,
		input osc_source_pick, ext_osc_input, func_enable,
		output d_dev_o, d_dev_oe,
		input d_bus
	);
endinterface

`default_nettype wire

// ### verilog/dhi_device.sv
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// - Three strap pins fix the host port type
// - Bus traffic only while chip-pick is low
// - Init pin low returns state to power-on
// - Select high: pixel byte, low: command
// - 6800 direction high reads, low writes
// - 6800 transfer starts on enable strobe high
// - 8080 write starts on write strobe low
// - 8080 read starts on read strobe low
// - 8080 reads: select picks pixels or status
// - Dummy read precedes first pixel read
// - Serial: bit 1 data, bit 0 clock
// - Serial shifts msb first on clock rise
// - Eighth serial clock samples select, stores byte
// - Oscillator strap picks internal or external clock
// - Function enable tied high to operate
// - Panel drives released while display is off
// - Pixel store 128 by 80 by 4 bits
module dhi_device (
	// Link to the host
	dhi_link_if.dev_mp lnk,
	// Panel drive enables and display timing
	output logic row_drive_oe,
	output logic column_drive_oe,
	output logic disp_tick,
	output logic [dhi_pkg::REMAP_W-1:0] remap_cfg,
	// Scan read port of the pixel store
	input wire logic [dhi_pkg::ADDR_W-1:0] scan_addr,
	output logic [7:0] scan_data,
	// Command bytes seen by the decoder
	output logic cmd_valid,
	output logic [7:0] cmd_byte
);
	import dhi_pkg::*;

	logic [PIN_W-1:0] pin_meta_ff, pin_s_ff;
	logic init_s, cs_s, dc_s, rw_s, e_s, fn_s, osc_s, ext_s;
	logic [2:0] pick_s;
	logic [7:0] d_s;
	logic chip_rst, sel, is6800, is8080, is_ser;
	logic e_prev_ff, rw_prev_ff, sclk_prev_ff, ext_prev_ff;
	logic par_wr, par_rd, rd_hold, ser_rise, ser_done;
	logic wr_stb, wr_dc, col_load, row_load, adv;
	logic [7:0] wr_byte, status_byte;
	dhi_mode_t mode_ff;
	logic osc_ext_ff;
	logic [6:0] shift_ff;
	logic [2:0] bit_cnt_ff;
	logic [COL_W-1:0] col_ff, col_start_ff, col_end_ff;
	logic [ROW_W-1:0] row_ff, row_start_ff, row_end_ff;
	logic [REMAP_W-1:0] remap_ff;
	logic disp_on_ff;
	logic [7:0] cmd_op_ff;
	logic [1:0] arg_left_ff;
	logic [7:0] rd_buf_ff, dout_ff, scan_data_ff, cmd_byte_ff;
	logic dout_oe_ff, cmd_valid_ff, tick_ff;
	logic [3:0] osc_cnt_ff;
	logic [7:0] pix_mem [0:MEM_BYTES-1];

	// Byte index of a pixel pair, column mirrored when remapped
	function automatic logic [ADDR_W-1:0] mem_index(input logic [COL_W-1:0] col,
		input logic [ROW_W-1:0] row, input logic [REMAP_W-1:0] remap);
		logic [COL_W-1:0] c;
		c = remap[REMAP_COL] ? COL_MAX - col : col;
		return {row, c};
	endfunction

	// Swap the two pixels of a byte when nibble remap is on
	function automatic logic [7:0] nib_swap(input logic [7:0] b,
		input logic [REMAP_W-1:0] remap);
		return remap[REMAP_NIB] ? {b[3:0], b[7:4]} : b;
	endfunction

	// Two flip-flops on every pin; the host runs on its own clock
	always_ff @(posedge lnk.link_clk) begin
		pin_meta_ff <= {lnk.init_pin_n, lnk.cs_n, lnk.dc, lnk.rw_wr_n, lnk.e_rd_n,
			lnk.func_enable, lnk.osc_source_pick, lnk.host_port_pick_2,
			lnk.host_port_pick_1, lnk.host_port_pick_0, lnk.ext_osc_input, lnk.d_bus};
		pin_s_ff <= pin_meta_ff;
	end

	assign {init_s, cs_s, dc_s, rw_s, e_s, fn_s, osc_s, pick_s, ext_s, d_s} = pin_s_ff;
	assign chip_rst = !init_s;
	assign sel = !cs_s && fn_s && !chip_rst;
	assign is6800 = mode_ff == DHI_M6800;
	assign is8080 = mode_ff == DHI_M8080;
	assign is_ser = mode_ff == DHI_MSER;

	// Previous levels for strobe edge detection
	always_ff @(posedge lnk.link_clk) begin
		e_prev_ff <= e_s;
		rw_prev_ff <= rw_s;
		sclk_prev_ff <= d_s[0];
		ext_prev_ff <= ext_s;
	end

	// Straps are followed while init is held and frozen at its release
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst) begin
			mode_ff <= pick_to_mode(pick_s);
			osc_ext_ff <= !osc_s;
		end
	end

	// Transfer starts; data and select were set up before the strobe
	assign par_wr = sel && ((is6800 && e_s && !e_prev_ff && !rw_s) ||
		(is8080 && !rw_s && rw_prev_ff));
	assign par_rd = sel && ((is6800 && e_s && !e_prev_ff && rw_s) ||
		(is8080 && !e_s && e_prev_ff));
	assign rd_hold = sel && ((is6800 && e_s && rw_s) || (is8080 && !e_s));
	assign ser_rise = sel && is_ser && d_s[0] && !sclk_prev_ff;
	assign ser_done = ser_rise && bit_cnt_ff == 3'h7;

	// Serial shift register, msb first, count restarts with chip-pick
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst || cs_s) begin
			shift_ff <= 7'h00;
			bit_cnt_ff <= 3'h0;
		end else if (ser_rise) begin
			shift_ff <= {shift_ff[5:0], d_s[1]};
			bit_cnt_ff <= bit_cnt_ff + 3'h1;
		end
	end

	// One write path for both port types
	assign wr_stb = par_wr || ser_done;
	assign wr_byte = ser_done ? {shift_ff, d_s[1]} : d_s;
	assign wr_dc = dc_s;
	assign col_load = wr_stb && !wr_dc && arg_left_ff == 2'h1 && cmd_op_ff == CMD_COL_ADDR;
	assign row_load = wr_stb && !wr_dc && arg_left_ff == 2'h1 && cmd_op_ff == CMD_ROW_ADDR;
	assign adv = (wr_stb && wr_dc) || (par_rd && dc_s);

	// Command decoder and its registers
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst) begin
			col_start_ff <= '0;
			col_end_ff <= COL_END_RST;
			row_start_ff <= '0;
			row_end_ff <= ROW_END_RST;
			remap_ff <= REMAP_RST;
			disp_on_ff <= 1'b0;
			cmd_op_ff <= 8'h00;
			arg_left_ff <= 2'h0;
		end else if (wr_stb && !wr_dc) begin
			if (arg_left_ff != 2'h0) begin
				arg_left_ff <= arg_left_ff - 2'h1;
				case (cmd_op_ff)
					CMD_COL_ADDR: if (arg_left_ff == 2'h2) begin
						col_start_ff <= wr_byte[COL_W-1:0];
					end else begin
						col_end_ff <= wr_byte[COL_W-1:0];
					end
					CMD_ROW_ADDR: if (arg_left_ff == 2'h2) begin
						row_start_ff <= wr_byte[ROW_W-1:0];
					end else begin
						row_end_ff <= wr_byte[ROW_W-1:0];
					end
					CMD_REMAP: remap_ff <= wr_byte[REMAP_W-1:0];
					default: ;
				endcase
			end else begin
				cmd_op_ff <= wr_byte;
				case (wr_byte)
					CMD_COL_ADDR: arg_left_ff <= 2'h2;
					CMD_ROW_ADDR: arg_left_ff <= 2'h2;
					CMD_REMAP: arg_left_ff <= 2'h1;
					CMD_DISP_OFF: disp_on_ff <= 1'b0;
					CMD_DISP_ON: disp_on_ff <= 1'b1;
					default: arg_left_ff <= 2'h0;
				endcase
			end
		end
	end

	// Address pointer inside the column and row window
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst) begin
			col_ff <= '0;
			row_ff <= '0;
		end else if (col_load) begin
			col_ff <= col_start_ff;
		end else if (row_load) begin
			row_ff <= row_start_ff;
		end else if (adv && !remap_ff[REMAP_VINC]) begin
			if (col_ff == col_end_ff) begin
				col_ff <= col_start_ff;
				row_ff <= (row_ff == row_end_ff) ? row_start_ff : row_ff + 7'h01;
			end else begin
				col_ff <= col_ff + 6'h01;
			end
		end else if (adv) begin
			if (row_ff == row_end_ff) begin
				row_ff <= row_start_ff;
				col_ff <= (col_ff == col_end_ff) ? col_start_ff : col_ff + 6'h01;
			end else begin
				row_ff <= row_ff + 7'h01;
			end
		end
	end

	// Pixel store writes; contents survive init like a real SRAM
	always_ff @(posedge lnk.link_clk) begin
		if (wr_stb && wr_dc) begin
			pix_mem[mem_index(col_ff, row_ff, remap_ff)] <= nib_swap(wr_byte, remap_ff);
		end
	end

	always_comb begin
		status_byte = 8'h00;
		status_byte[STAT_OFF_BIT] = !disp_on_ff;
	end

	// Pipelined read: each pixel read returns the byte fetched last time
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst) begin
			rd_buf_ff <= 8'h00;
			dout_ff <= 8'h00;
		end else if (par_rd && dc_s) begin
			dout_ff <= rd_buf_ff;
			rd_buf_ff <= nib_swap(pix_mem[mem_index(col_ff, row_ff, remap_ff)], remap_ff);
		end else if (par_rd) begin
			dout_ff <= status_byte;
		end
	end

	// Bus drive only while the read strobe stays active
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst) begin
			dout_oe_ff <= 1'b0;
		end else begin
			dout_oe_ff <= par_rd || (dout_oe_ff && rd_hold);
		end
	end

	// Display clock from the internal divider or the external pin
	always_ff @(posedge lnk.link_clk) begin
		if (chip_rst) begin
			osc_cnt_ff <= 4'h0;
			tick_ff <= 1'b0;
		end else begin
			osc_cnt_ff <= (osc_cnt_ff == OSC_DIV_LAST || osc_ext_ff) ? 4'h0 : osc_cnt_ff + 4'h1;
			tick_ff <= osc_ext_ff ? (ext_s && !ext_prev_ff) : (osc_cnt_ff == OSC_DIV_LAST);
		end
	end

	// Scan port and command report
	always_ff @(posedge lnk.link_clk) begin
		scan_data_ff <= pix_mem[scan_addr];
		if (chip_rst) begin
			cmd_valid_ff <= 1'b0;
			cmd_byte_ff <= 8'h00;
		end else begin
			cmd_valid_ff <= wr_stb && !wr_dc;
			if (wr_stb && !wr_dc) cmd_byte_ff <= wr_byte;
		end
	end

	assign lnk.d_dev_o = dout_ff;
	assign lnk.d_dev_oe = dout_oe_ff;
	assign row_drive_oe = disp_on_ff;
	assign column_drive_oe = disp_on_ff;
	assign disp_tick = tick_ff;
	assign remap_cfg = remap_ff;
	assign scan_data = scan_data_ff;
	assign cmd_valid = cmd_valid_ff;
	assign cmd_byte = cmd_byte_ff;
endmodule

`default_nettype wire

// ### tb/dhi_link_sva.sv
`timescale 1ns/100ps
`default_nettype none

module dhi_link_sva (
	// Clocks and resets
	input wire logic clk_sys,
	input wire logic rst_n,
	input wire logic link_clk,
	input wire logic init_pin_n,
	// Host pins
	input wire logic cs_n,
	input wire logic rw_wr_n,
	input wire logic e_rd_n,
	input wire logic host_port_pick_0,
	input wire logic host_port_pick_1,
	input wire logic host_port_pick_2,
	input wire logic [7:0] d_host_o,
	input wire logic d_host_oe,
	// Device pins
	input wire logic d_dev_oe
);
	import dhi_pkg::*;
	logic [2:0] pk;

	// Straps as one field
	assign pk = {host_port_pick_2, host_port_pick_1, host_port_pick_0};

	// Host side, checked in the system clock domain
	chk_init_after_rst: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$rose(rst_n) |-> (!init_pin_n && cs_n)[*8]) else $error("init pin not held");
	chk_strap_frozen: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) && $past(rst_n, 2) |-> $stable(pk)) else $error("straps moved");
	chk_write_in_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
		$past(rst_n) && pk == PICK_8080 && !rw_wr_n |-> !cs_n) else $error("stray write");
	chk_sclk_in_cs: assert property (@(posedge clk_sys) disable iff (!rst_n)
		pk == PICK_SER && d_host_oe && $rose(d_host_o[0]) |-> !cs_n) else $error("stray sclk");
	// Link side; strobe phases span whole link periods
	chk_strobe_long: assert property (@(posedge link_clk) disable iff (!init_pin_n)
		pk == PICK_8080 && $fell(rw_wr_n) |-> !rw_wr_n[*8]) else $error("short strobe");
	chk_bus_owner: assert property (@(posedge link_clk) disable iff (!init_pin_n)
		d_dev_oe |-> !cs_n && !d_host_oe && pk != PICK_SER) else $error("bus clash");
	chk_read_8080: assert property (@(posedge link_clk) disable iff (!init_pin_n)
		pk == PICK_8080 && !cs_n && $fell(e_rd_n) |-> ##[2:6] d_dev_oe)
		else $error("no 8080 read data");
	chk_read_6800: assert property (@(posedge link_clk) disable iff (!init_pin_n)
		pk == PICK_6800 && !cs_n && rw_wr_n && $rose(e_rd_n) |-> ##[2:6] d_dev_oe)
		else $error("no 6800 read data");

	// Main traffic kinds
	cov_dev_read: cover property (@(posedge link_clk) $rose(d_dev_oe));
	cov_wr_8080: cover property (@(posedge link_clk) pk == PICK_8080 && $fell(rw_wr_n));
	cov_ser_bit: cover property (@(posedge clk_sys) pk == PICK_SER && $rose(d_host_o[0]));
endmodule

`default_nettype wire

// ### tb/display_host_interface_test.sv
`timescale 1ns/100ps
`default_nettype none

module display_host_interface_test;
	import dhi_pkg::*;
	localparam int LIMIT = 60000;
	logic clk_sys = 1'b0;
	logic rst_n = 1'b0;
	dhi_mode_t port_mode = DHI_M8080;
	logic osc_internal = 1'b1;
	logic req_valid = 1'b0;
	logic req_read = 1'b0;
	logic req_dc = 1'b0;
	logic [7:0] req_data = 8'h00;
	logic [ADDR_W-1:0] scan_addr = 13'h0000;
	logic req_ready, rsp_valid, row_drive_oe, column_drive_oe, disp_tick, cmd_valid, sclk_q;
	logic [7:0] rsp_data, scan_data, cmd_byte, last_cmd, wire_byte;
	logic [REMAP_W-1:0] remap_cfg;
	int err_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int n_cmd = 0;
	int n_tick = 0;
	int t0;
	dhi_mode_t modes [3] = '{DHI_M8080, DHI_M6800, DHI_MSER};
	dhi_link_if lnk();

	dhi_host u_dhi_host (.clk_sys(clk_sys), .rst_n(rst_n), .port_mode(port_mode),
		.osc_internal(osc_internal), .req_valid(req_valid), .req_ready(req_ready),
		.req_read(req_read), .req_dc(req_dc), .req_data(req_data), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .lnk(lnk));
	dhi_device u_dhi_device (.lnk(lnk), .row_drive_oe(row_drive_oe),
		.column_drive_oe(column_drive_oe), .disp_tick(disp_tick), .remap_cfg(remap_cfg),
		.scan_addr(scan_addr), .scan_data(scan_data), .cmd_valid(cmd_valid), .cmd_byte(cmd_byte));
	dhi_link_sva u_dhi_link_sva (.clk_sys(clk_sys), .rst_n(rst_n), .link_clk(lnk.link_clk),
		.init_pin_n(lnk.init_pin_n), .cs_n(lnk.cs_n), .rw_wr_n(lnk.rw_wr_n),
		.e_rd_n(lnk.e_rd_n), .host_port_pick_0(lnk.host_port_pick_0),
		.host_port_pick_1(lnk.host_port_pick_1), .host_port_pick_2(lnk.host_port_pick_2),
		.d_host_o(lnk.d_host_o), .d_host_oe(lnk.d_host_oe), .d_dev_oe(lnk.d_dev_oe));

	// System clock, 25 ns
	always #12.5 clk_sys = ~clk_sys;

	// Hang guard, about twice the expected run
	always @(posedge clk_sys) begin
		cycles <= cycles + 1;
		if (cycles == LIMIT) begin
			err_count++;
			print_verdict();
		end
	end

	// Own view of commands, ticks and the serial wire (msb first)
	always @(posedge lnk.link_clk) begin
		sclk_q <= lnk.d_bus[0];
		if (cmd_valid === 1'b1) begin
			last_cmd <= cmd_byte;
			n_cmd <= n_cmd + 1;
		end
		if (disp_tick === 1'b1)
			n_tick <= n_tick + 1;
		if (!lnk.cs_n && lnk.d_bus[0] && !sclk_q)
			wire_byte <= {wire_byte[6:0], lnk.d_bus[1]};
	end

	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// One request, held until the queue takes it
	task automatic put(input logic r, input logic dc, input logic [7:0] d);
		req_valid <= 1'b1;
		req_read <= r;
		req_dc <= dc;
		req_data <= d;
		@(posedge clk_sys);
		for (int i = 0; i < 5000 && req_ready !== 1'b1; i++) @(posedge clk_sys);
		req_valid <= 1'b0;
		@(posedge clk_sys);
	endtask

	task automatic rd(input logic dc, input logic [7:0] d);
		put(1'b1, dc, 8'h00);
		for (int i = 0; i < 3000 && rsp_valid !== 1'b1; i++) @(posedge clk_sys);
		check(rsp_data, d);
	endtask

	// Command write; settle margin lets decoded state land
	task automatic wcmd(input logic [7:0] d);
		int n;
		n = n_cmd;
		put(1'b0, 1'b0, d);
		for (int i = 0; i < 3000 && n_cmd == n; i++) @(posedge clk_sys);
		repeat (16) @(posedge clk_sys);
		check(last_cmd, d);
		if (port_mode == DHI_MSER)
			check(wire_byte, d);
	endtask

	task automatic win();
		wcmd(CMD_COL_ADDR);
		wcmd(8'h00);
		wcmd(COL_MAX);
	endtask

	task automatic scan(input logic [ADDR_W-1:0] a, input logic [7:0] d);
		scan_addr <= a;
		for (int i = 0; i < 15000 && scan_data !== d; i++) @(posedge clk_sys);
		check(scan_data, d);
	endtask

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	// One pass per host port type, reset in between
	initial begin
		for (int m = 0; m < 3; m++) begin
			@(posedge clk_sys);
			rst_n <= 1'b0;
			port_mode <= modes[m];
			osc_internal <= (m != 1);
			repeat (3) @(posedge clk_sys);
			rst_n <= 1'b1;
			t0 = n_tick;
			wcmd(CMD_DISP_ON);
			check({1'b0, remap_cfg}, {1'b0, REMAP_RST});
			check({7'h00, row_drive_oe}, 8'h01);
			win();
			// Nine bytes overfill the eight-deep queue
			for (int i = 0; i < 9; i++)
				put(1'b0, 1'b1, {4'h5 + m[3:0], i[3:0]});
			@(posedge clk_sys);
			check({7'h00, req_ready}, 8'h00);
			for (int i = 8; i >= 0; i--)
				scan(ADDR_W'(i), {4'h5 + m[3:0], i[3:0]});
			if (m < 2) begin
				win();
				rd(1'b1, {4'h5 + m[3:0], 4'h0});
				rd(1'b1, {4'h5 + m[3:0], 4'h1});
				rd(1'b0, 8'h00);
			end
			wcmd(CMD_DISP_OFF);
			check({6'h00, row_drive_oe, column_drive_oe}, 8'h00);
			if (m < 2)
				rd(1'b0, 8'h40);
			wcmd(CMD_REMAP);
			wcmd(8'h05);
			check({1'b0, remap_cfg}, 8'h05);
			check({7'h00, n_tick > t0}, 8'h01);
			$display("test mode %0d done", m);
		end
		print_verdict();
	end
endmodule

`default_nettype wire
